// *** src/nmhp_params.svh ***
// Notes on behaviour
// - 15-bit address, 8-bit two-way data bus.
// - Select low gates every bus strobe.
// - Read strobe low requests addressed byte.
// - Write strobe low stores bus byte.
// - Reception or transmission events assert interrupt low.
// - Host write to cause register clears interrupt.
// - Each interrupt source masked by mask register.
// - Collision indicator low during collision only.
// - Fast indicator low at 100, blinks on traffic.
// - Slow indicator low at 10, blinks on traffic.
// - Link indicator low whenever link established.
// - Speed detected automatically, no host setting.
// - Offload reset restores registers, re-samples straps.
`ifndef NMHP_PARAMS_SVH
`define NMHP_PARAMS_SVH

// ************************************************************
// Bus widths
// ************************************************************
`define NMHP_ADDR_W        15
`define NMHP_DATA_W        8

// ************************************************************
// Address map
// ************************************************************
`define NMHP_ADDR_CAUSE    15'h0000
`define NMHP_ADDR_MASK     15'h0001
`define NMHP_ADDR_STATUS   15'h0002
`define NMHP_BUF_BASE      15'h0100
`define NMHP_BUF_DEPTH     256

// ************************************************************
// Cause and status bit positions, reset values
// ************************************************************
`define NMHP_BIT_RX        0
`define NMHP_BIT_TX        1
`define NMHP_BIT_COL       2
`define NMHP_BIT_LINK      3
`define NMHP_ST_BIT_LINK   0
`define NMHP_ST_BIT_FAST   1
`define NMHP_ST_BIT_STRAP  2
`define NMHP_CAUSE_RESET   8'h00
`define NMHP_MASK_RESET    8'h0F
`define NMHP_DATA_IDLE     8'h00

// ************************************************************
// Timing
// ************************************************************
`define NMHP_CLOCK_KHZ     20000
`define NMHP_BLINK_HALF_MS 50

`endif

// *** src/nmhp_pkg.sv ***
package nmhp_pkg;

  // Bus handshake states, Gray along idle-write-commit
  typedef enum logic [1:0] {
    NMHP_ST_IDLE   = 2'h0,
    NMHP_ST_WRITE  = 2'h1,
    NMHP_ST_COMMIT = 2'h3,
    NMHP_ST_READ   = 2'h2
  } nmhp_state_t;

  // Decoded address regions
  typedef enum logic [2:0] {
    NMHP_RG_CAUSE  = 3'h0,
    NMHP_RG_MASK   = 3'h1,
    NMHP_RG_STATUS = 3'h2,
    NMHP_RG_BUF    = 3'h3,
    NMHP_RG_NONE   = 3'h4
  } nmhp_region_t;

endpackage

// *** src/nmhp_blink.sv ***
`timescale 1ns/100ps
`include "nmhp_params.svh"

// ************************************************************
// Activity blinker: dark half periods, each followed by a lit half, repeat while traffic goes on
// ************************************************************
module nmhp_blink
  import nmhp_pkg::*;
#(
  parameter int HALF_CYCLES = `NMHP_BLINK_HALF_MS * `NMHP_CLOCK_KHZ
) (
  input  wire logic i_clock,    // System clock
  input  wire logic i_reset,    // Async reset, high
  input  wire logic i_activity, // Traffic seen this cycle
  output logic      o_blank     // High while indicator goes dark
);

  localparam int CW = $clog2(HALF_CYCLES + 1);

  logic [CW-1:0] count_reg;     // Divider count
  logic [CW-1:0] count_next;
  logic          tick;          // One-cycle enable per half period
  logic          phase_reg;     // Dark half active
  logic          phase_next;
  logic          pend_reg;      // Traffic waiting for a blink
  logic          pend_next;

  // Divider and blink phase
  always_comb
  begin
    tick       = (count_reg == CW'(HALF_CYCLES - 1));
    count_next = tick ? '0 : count_reg + 1'b1;
    phase_next = phase_reg;
    pend_next  = pend_reg | i_activity;
    if (tick)
    begin
      // Dark half always followed by a lit half, so blinks stay visible
      if (phase_reg)
        phase_next = 1'b0;
      else if (pend_reg)
      begin
        phase_next = 1'b1;
        pend_next  = i_activity;
      end
    end
  end

  // Registers
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      count_reg <= '0;
      phase_reg <= 1'b0;
      pend_reg  <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      phase_reg <= phase_next;
      pend_reg  <= pend_next;
    end
  end

  assign o_blank = phase_reg;

endmodule // nmhp_blink

// *** src/nmhp_host_port.sv ***
`timescale 1ns/100ps
`include "nmhp_params.svh"

// ************************************************************
// Network module host port: bus slave, interrupt, indicators
// ************************************************************
module nmhp_host_port
  import nmhp_pkg::*;
#(
  parameter int ADDR_W      = `NMHP_ADDR_W,
  parameter int DATA_W      = `NMHP_DATA_W,
  parameter int BUF_DEPTH   = `NMHP_BUF_DEPTH,
  parameter int HALF_CYCLES = `NMHP_BLINK_HALF_MS * `NMHP_CLOCK_KHZ
) (
  input  wire logic              i_clock,                    // 20 MHz clock
  input  wire logic              i_reset,                    // Async reset, high
  input  wire logic              i_offload_reset,            // Offload reset, high
  input  wire logic              i_phy_reset_n,              // Physical reset, low
  input  wire logic [1:0]        i_strap_mode,               // Strap level
  input  wire logic [ADDR_W-1:0] i_host_address,             // Host address
  input  wire logic [DATA_W-1:0] i_host_data,                // Data bus in
  output logic      [DATA_W-1:0] o_host_data,                // Data bus out
  output logic                   o_host_data_oe_n,           // Low while driving
  input  wire logic              i_select_n,                 // Module select, low
  input  wire logic              i_read_n,                   // Read strobe, low
  input  wire logic              i_write_n,                  // Write strobe, low
  output logic                   o_irq_n,                    // Attention, low
  input  wire logic              i_rx_event,                 // Reception done pulse
  input  wire logic              i_tx_event,                 // Transmission done pulse
  input  wire logic              i_link_up,                  // Line link status
  input  wire logic              i_speed_fast,               // Negotiated 100 speed
  input  wire logic              i_collision,                // Collision on line
  input  wire logic              i_activity,                 // Traffic on line
  output logic                   o_collision_led_n,          // Collision LED, low
  output logic                   o_fast_link_activity_led_n, // 100 link LED, low
  output logic                   o_slow_link_activity_led_n, // 10 link LED, low
  output logic                   o_link_led_n                // Link LED, low
);

  localparam int BUF_AW = $clog2(BUF_DEPTH);

  // ************************************************************
  // Declarations
  // ************************************************************
  nmhp_state_t       state_reg;       // Bus handshake state
  nmhp_state_t       state_next;
  logic [ADDR_W-1:0] wr_addr_reg;     // Address held through write strobe
  logic [ADDR_W-1:0] wr_addr_next;
  logic [DATA_W-1:0] wr_data_reg;     // Data held through write strobe
  logic [DATA_W-1:0] wr_data_next;
  logic [DATA_W-1:0] cause_reg;       // Interrupt cause register
  logic [DATA_W-1:0] cause_next;
  logic [DATA_W-1:0] mask_reg;        // Interrupt mask register
  logic [DATA_W-1:0] mask_next;
  logic [DATA_W-1:0] set_vec;         // Hardware events this cycle
  logic [DATA_W-1:0] clr_vec;         // Host clear bits this cycle
  logic              irq_n_reg;       // Interrupt pin
  logic              irq_n_next;
  logic [DATA_W-1:0] rd_data_reg;     // Data bus output
  logic [DATA_W-1:0] rd_data_next;
  logic [1:0]        strap_reg;       // Latched strap level
  logic [1:0]        strap_next;
  logic              strap_pend_reg;  // Strap capture owed
  logic              strap_pend_next;
  logic              link_prev_reg;   // Link a cycle ago
  logic              col_prev_reg;    // Collision a cycle ago
  logic [3:0]        led_reg;         // Col, fast, slow, link LEDs
  logic [3:0]        led_next;
  logic              sel_rd;          // Qualified read
  logic              sel_wr;          // Qualified write
  logic              commit;          // Store held write now
  logic              link_now;        // Link seen, physical side alive
  logic              col_now;         // Collision seen, physical side alive
  logic              blank;           // Blink dark phase
  logic [DATA_W-1:0] buf_mem [BUF_DEPTH]; // Packet buffer window

  // 15-bit address decode
  // Address decode, shared by read and write paths
  function automatic nmhp_region_t decode(input logic [ADDR_W-1:0] addr);
    if (addr == `NMHP_ADDR_CAUSE)
      return NMHP_RG_CAUSE;
    if (addr == `NMHP_ADDR_MASK)
      return NMHP_RG_MASK;
    if (addr == `NMHP_ADDR_STATUS)
      return NMHP_RG_STATUS;
    if (addr >= `NMHP_BUF_BASE && addr < `NMHP_BUF_BASE + ADDR_W'(BUF_DEPTH))
      return NMHP_RG_BUF;
    return NMHP_RG_NONE;
  endfunction

  function automatic logic [BUF_AW-1:0] buf_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] off;
    off = addr - `NMHP_BUF_BASE;
    return off[BUF_AW-1:0];
  endfunction

  // ************************************************************
  // Bus handshake
  // ************************************************************
  // strobes need select
  assign sel_rd = !i_select_n && !i_read_n && !i_offload_reset;
  assign sel_wr = !i_select_n && !i_write_n && !i_offload_reset;

  // Write is committed after the strobe ends, so data settled late still lands
  always_comb
  begin
    state_next   = state_reg;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    commit       = 1'b0;
    unique case (state_reg)
      NMHP_ST_IDLE:
        if (sel_wr)
        begin
          state_next   = NMHP_ST_WRITE;
          wr_addr_next = i_host_address;
          wr_data_next = i_host_data;
        end
        else if (sel_rd)
          state_next = NMHP_ST_READ;
      NMHP_ST_WRITE:
        // Track bus until strobe or select rises
        if (sel_wr)
        begin
          wr_addr_next = i_host_address;
          wr_data_next = i_host_data;
        end
        else
          state_next = NMHP_ST_COMMIT;
      NMHP_ST_COMMIT:
      begin
        commit     = !i_offload_reset;
        state_next = NMHP_ST_IDLE;
      end
      NMHP_ST_READ:
        if (!sel_rd)
          state_next = NMHP_ST_IDLE;
    endcase
    if (i_offload_reset)
      state_next = NMHP_ST_IDLE;
  end

  // ************************************************************
  // Interrupt cause and mask
  // ************************************************************
  assign link_now = i_link_up && i_phy_reset_n;
  assign col_now  = i_collision && i_phy_reset_n;

  // Events beat a simultaneous host clear
  always_comb
  begin
    set_vec = '0;
    clr_vec = '0;
    set_vec[`NMHP_BIT_RX]   = i_rx_event;
    set_vec[`NMHP_BIT_TX]   = i_tx_event;
    set_vec[`NMHP_BIT_COL]  = col_now && !col_prev_reg;
    set_vec[`NMHP_BIT_LINK] = link_now ^ link_prev_reg;
    if (commit && decode(wr_addr_reg) == NMHP_RG_CAUSE)
      clr_vec = wr_data_reg;
    cause_next = (cause_reg & ~clr_vec) | set_vec;
    mask_next  = (commit && decode(wr_addr_reg) == NMHP_RG_MASK) ? wr_data_reg : mask_reg;
    strap_next      = strap_reg;
    strap_pend_next = strap_pend_reg;
    if (i_offload_reset)
    begin
      cause_next      = `NMHP_CAUSE_RESET;
      mask_next       = `NMHP_MASK_RESET;
      strap_pend_next = 1'b1;
    end
    else if (strap_pend_reg)
    begin
      // Straps taken on the first cycle after reset release
      strap_next      = i_strap_mode;
      strap_pend_next = 1'b0;
    end
    irq_n_next = ~|(cause_next & mask_next);
  end

  // ************************************************************
  // Read data path
  // ************************************************************
  // addressed byte registered
  always_comb
  begin
    rd_data_next = `NMHP_DATA_IDLE;
    if (sel_rd)
    begin
      unique case (decode(i_host_address))
        NMHP_RG_CAUSE:  rd_data_next = cause_reg;
        NMHP_RG_MASK:   rd_data_next = mask_reg;
        NMHP_RG_STATUS:
        begin
          rd_data_next[`NMHP_ST_BIT_LINK] = link_now;
          rd_data_next[`NMHP_ST_BIT_FAST] = i_speed_fast;
          rd_data_next[`NMHP_ST_BIT_STRAP +: 2] = strap_reg;
        end
        NMHP_RG_BUF:    rd_data_next = buf_mem[buf_index(i_host_address)];
        NMHP_RG_NONE:   rd_data_next = `NMHP_DATA_IDLE;
      endcase
    end
  end

  assign o_host_data_oe_n = !sel_rd;
  assign o_host_data      = rd_data_reg;
  assign o_irq_n          = irq_n_reg;

  // ************************************************************
  // Indicators
  // ************************************************************
  nmhp_blink #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_blink (
    .i_clock    (i_clock),
    .i_reset    (i_reset),
    .i_activity (i_activity && link_now),
    .o_blank    (blank)
  );

  // Speed taken from line negotiation, never from a host setting
  always_comb
  begin
    led_next[3] = !col_now;
    led_next[2] = !(link_now && i_speed_fast && !blank);
    led_next[1] = !(link_now && !i_speed_fast && !blank);
    led_next[0] = !link_now;
  end

  assign o_collision_led_n          = led_reg[3];
  assign o_fast_link_activity_led_n = led_reg[2];
  assign o_slow_link_activity_led_n = led_reg[1];
  assign o_link_led_n               = led_reg[0];

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_reg      <= NMHP_ST_IDLE;
      wr_addr_reg    <= '0;
      wr_data_reg    <= '0;
      cause_reg      <= `NMHP_CAUSE_RESET;
      mask_reg       <= `NMHP_MASK_RESET;
      irq_n_reg      <= 1'b1;
      rd_data_reg    <= `NMHP_DATA_IDLE;
      strap_reg      <= '0;
      strap_pend_reg <= 1'b1;
      link_prev_reg  <= 1'b0;
      col_prev_reg   <= 1'b0;
      led_reg        <= '1;
    end
    else
    begin
      state_reg      <= state_next;
      wr_addr_reg    <= wr_addr_next;
      wr_data_reg    <= wr_data_next;
      cause_reg      <= cause_next;
      mask_reg       <= mask_next;
      irq_n_reg      <= irq_n_next;
      rd_data_reg    <= rd_data_next;
      strap_reg      <= strap_next;
      strap_pend_reg <= strap_pend_next;
      link_prev_reg  <= link_now;
      col_prev_reg   <= col_now;
      led_reg        <= led_next;
    end
  end

  // Buffer storage, left unreset: contents are packet data, not control
  always_ff @(posedge i_clock)
  begin
    if (commit && decode(wr_addr_reg) == NMHP_RG_BUF)
      buf_mem[buf_index(wr_addr_reg)] <= wr_data_reg;
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  property p_drive_window;
    !o_host_data_oe_n |-> !i_select_n && !i_read_n && !i_offload_reset;
  endproperty
  a_drive_window: assert property (p_drive_window) else $error("data driven outside read");

  property p_select_idle;
    i_select_n && state_reg != NMHP_ST_WRITE |=> state_reg == NMHP_ST_IDLE;
  endproperty
  a_select_idle: assert property (p_select_idle) else $error("strobe acted without select");

  property p_read_mask;
    sel_rd && i_host_address == `NMHP_ADDR_MASK |=> o_host_data == $past(mask_reg);
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("mask read returned wrong byte");

  property p_write_mask;
    sel_wr ##1 !sel_wr && !i_offload_reset && decode(wr_addr_reg) == NMHP_RG_MASK
      ##1 !i_offload_reset |=> mask_reg == $past(wr_data_reg, 2);
  endproperty
  a_write_mask: assert property (p_write_mask) else $error("mask write not stored");

  property p_event_irq;
    i_rx_event && mask_next[`NMHP_BIT_RX] && !i_offload_reset |=> !o_irq_n;
  endproperty
  a_event_irq: assert property (p_event_irq) else $error("event did not raise interrupt");

  property p_clear_irq;
    commit && decode(wr_addr_reg) == NMHP_RG_CAUSE && (cause_reg & ~wr_data_reg) == '0
      && set_vec == '0
      |=> o_irq_n && cause_reg == '0;
  endproperty
  a_clear_irq: assert property (p_clear_irq) else $error("cause write left interrupt");

  property p_mask_quiet;
    o_irq_n && (set_vec & mask_next) == '0 && mask_next == mask_reg |=> o_irq_n;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("masked event raised interrupt");

  property p_collision;
    col_now |=> !o_collision_led_n;
  endproperty
  a_collision: assert property (p_collision) else $error("collision LED not lit");

  property p_fast_led;
    link_now && i_speed_fast |=> o_slow_link_activity_led_n
      && o_fast_link_activity_led_n == $past(blank);
  endproperty
  a_fast_led: assert property (p_fast_led) else $error("fast link LEDs wrong");

  property p_link_led;
    !link_now [*2] |-> o_link_led_n;
  endproperty
  a_link_led: assert property (p_link_led) else $error("link LED lit without link");

  property p_offload_reset;
    i_offload_reset |=> mask_reg == `NMHP_MASK_RESET && cause_reg == `NMHP_CAUSE_RESET
      && o_irq_n && strap_pend_reg;
  endproperty
  a_offload_reset: assert property (p_offload_reset) else $error("offload reset incomplete");

  c_buf_write: cover property (commit && decode(wr_addr_reg) == NMHP_RG_BUF);
  c_read:      cover property (sel_rd [*2]);
  c_irq:       cover property ($fell(o_irq_n));
  c_blink:     cover property ($rose(blank));

endmodule // nmhp_host_port

// *** dv/nmhp_host_model.sv ***
`timescale 1ns/100ps

// ************************************************************
// Host controller model on the asynchronous byte bus
// ************************************************************
module nmhp_host_model #(
  parameter int OFF_HOLD = 200, // 10 us at 50 ns
  parameter int PHY_HOLD = 400  // Shortened physical reset hold
) (
  input  wire logic        i_clock,         // System clock
  input  wire logic [7:0]  i_bus,           // Resolved data bus
  input  wire logic        i_oe_n,          // Device drive enable
  output logic             o_select_n,      // Module select, low
  output logic             o_read_n,        // Read strobe, low
  output logic             o_write_n,       // Write strobe, low
  output logic [14:0]      o_address,       // Host address
  output logic [7:0]       o_data,          // Host side of data bus
  output logic             o_offload_reset, // Offload reset, high
  output logic             o_phy_reset_n    // Physical reset, low
);
  logic [7:0] last_data; // Released bus shows the inverse of this

  // Idle bus, both resets inactive
  initial
  begin
    o_select_n = 1'b1;
    o_read_n = 1'b1;
    o_write_n = 1'b1;
    o_address = 15'h0000;
    last_data = 8'h00;
    o_data = 8'hFF;
    o_offload_reset = 1'b0;
    o_phy_reset_n = 1'b1;
  end

  // strobe and data held two cycles
  task automatic write_byte(input logic [14:0] addr, input logic [7:0] data,
                            input logic sel_n);
    @(negedge i_clock);
    o_address = addr;
    o_data = data;
    last_data = data;
    o_select_n = sel_n;
    o_write_n = 1'b0;
    repeat (2) @(negedge i_clock);
    o_select_n = 1'b1;
    o_write_n = 1'b1;
    o_data = ~last_data;
    // Leave room for the commit before the next strobe
    repeat (4) @(negedge i_clock);
  endtask

  // read strobe, data taken after two edges
  task automatic read_byte(input logic [14:0] addr, input logic sel_n,
                           output logic [7:0] data, output logic oe_n);
    @(negedge i_clock);
    o_address = addr;
    o_select_n = sel_n;
    o_read_n = 1'b0;
    repeat (2) @(negedge i_clock);
    data = i_bus;
    oe_n = i_oe_n;
    o_select_n = 1'b1;
    o_read_n = 1'b1;
    @(negedge i_clock);
  endtask

  task automatic pulse_offload();
    @(negedge i_clock);
    o_offload_reset = 1'b1;
    repeat (OFF_HOLD) @(negedge i_clock);
    o_offload_reset = 1'b0;
  endtask

  // physical reset held low its full time
  task automatic phy_assert();
    @(negedge i_clock);
    o_phy_reset_n = 1'b0;
    repeat (PHY_HOLD) @(negedge i_clock);
  endtask

  task automatic phy_release();
    o_phy_reset_n = 1'b1;
    repeat (3) @(negedge i_clock);
  endtask
endmodule // nmhp_host_model

// *** dv/nmhp_host_port_tb.sv ***
`timescale 1ns/100ps

// ************************************************************
// Self-checking bench for the host port
// ************************************************************
module nmhp_host_port_tb;
  localparam int HALF = 8; // Short blink half period

  logic        clock, reset, rx, tx, link, fast, col, act;   // Stimulus
  logic [1:0]  strap;                                        // Strap level
  logic        sel_n, rd_n, wr_n, off_rst, phy_rst_n;        // Host lines
  logic [14:0] addr;                                         // Host address
  logic [7:0]  h_data, d_data, bus_w, rd;                    // Data paths
  logic        oe_n, irq_n, col_n, fast_n, slow_n, link_n, oe; // Outputs
  int          err_count, cmp_count;                         // Tallies
  // Rows: write flag, address, data or expected byte
  logic [23:0] rows [10] = '{24'h8100A5, 24'h81FF3C, 24'h8002FF, 24'h0100A5,
    24'h01FF3C, 24'h000208, 24'h000000, 24'h00010F, 24'h7FFF00, 24'h000300};

  // Device wins the bus only while it enables its driver
  assign bus_w = oe_n ? h_data : d_data;

  nmhp_host_port #(.HALF_CYCLES(HALF)) dut_u (
    .i_clock(clock), .i_reset(reset), .i_offload_reset(off_rst),
    .i_phy_reset_n(phy_rst_n), .i_strap_mode(strap), .i_host_address(addr),
    .i_host_data(bus_w), .o_host_data(d_data), .o_host_data_oe_n(oe_n),
    .i_select_n(sel_n), .i_read_n(rd_n), .i_write_n(wr_n), .o_irq_n(irq_n),
    .i_rx_event(rx), .i_tx_event(tx), .i_link_up(link), .i_speed_fast(fast),
    .i_collision(col), .i_activity(act), .o_collision_led_n(col_n),
    .o_fast_link_activity_led_n(fast_n), .o_slow_link_activity_led_n(slow_n),
    .o_link_led_n(link_n));

  nmhp_host_model #(.PHY_HOLD(400)) host_u (
    .i_clock(clock), .i_bus(bus_w), .i_oe_n(oe_n), .o_select_n(sel_n),
    .o_read_n(rd_n), .o_write_n(wr_n), .o_address(addr), .o_data(h_data),
    .o_offload_reset(off_rst), .o_phy_reset_n(phy_rst_n));

  // ************************************************************
  // Clock and helpers
  // ************************************************************
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One-cycle event pulses, then time for the interrupt to settle
  task automatic ev(input logic r, input logic t);
    @(negedge clock);
    rx = r;
    tx = t;
    @(negedge clock);
    rx = 1'b0;
    tx = 1'b0;
    repeat (2) @(negedge clock);
  endtask

  // Bounded wait on the fast indicator; running out ends the run
  task automatic wait_fast(input logic val, input int lim);
    int n;
    n = 0;
    while (fast_n !== val && n < lim)
    begin
      @(negedge clock);
      n++;
    end
    chk("fast_led_wait", {7'h00, fast_n}, {7'h00, val});
    if (fast_n !== val)
      summarize();
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    {rx, tx, link, fast, col, act} = 6'h00;
    strap = 2'h2;
    err_count = 0;
    cmp_count = 0;
    reset = 1'b1;
    repeat (12) @(negedge clock);
    reset = 1'b0;
    repeat (2) @(negedge clock);
    chk("idle_outputs", {2'h0, oe_n, irq_n, col_n, fast_n, slow_n, link_n}, 8'h3F);
    // Ordinary accesses from the table
    foreach (rows[i])
    begin
      if (rows[i][23])
        host_u.write_byte(rows[i][22:8], rows[i][7:0], 1'b0);
      else
      begin
        host_u.read_byte(rows[i][22:8], 1'b0, rd, oe);
        chk("read_data", rd, rows[i][7:0]);
        chk("drive_en_n", {7'h00, oe}, 8'h00);
      end
    end
    // Strobes without select are ignored
    host_u.write_byte(15'h0100, 8'h11, 1'b1);
    host_u.read_byte(15'h0100, 1'b1, rd, oe);
    chk("drive_en_unselected", {7'h00, oe}, 8'h01);
    host_u.read_byte(15'h0100, 1'b0, rd, oe);
    chk("buffer_kept", rd, 8'hA5);
    // Interrupt raise, clear and mask
    ev(1'b1, 1'b0);
    chk("irq_rx", {7'h00, irq_n}, 8'h00);
    host_u.write_byte(15'h0000, 8'h01, 1'b0);
    chk("irq_cleared", {7'h00, irq_n}, 8'h01);
    host_u.write_byte(15'h0001, 8'h0E, 1'b0);
    ev(1'b1, 1'b0);
    chk("irq_masked", {7'h00, irq_n}, 8'h01);
    host_u.read_byte(15'h0000, 1'b0, rd, oe);
    chk("cause_masked", rd, 8'h01);
    ev(1'b0, 1'b1);
    chk("irq_tx", {7'h00, irq_n}, 8'h00);
    // Offload reset restores defaults
    host_u.pulse_offload();
    chk("irq_after_reset", {7'h00, irq_n}, 8'h01);
    host_u.read_byte(15'h0001, 1'b0, rd, oe);
    chk("mask_default", rd, 8'h0F);
    host_u.read_byte(15'h0000, 1'b0, rd, oe);
    chk("cause_default", rd, 8'h00);
    // Collision indicator
    col = 1'b1;
    repeat (2) @(negedge clock);
    chk("col_on", {7'h00, col_n}, 8'h00);
    col = 1'b0;
    repeat (2) @(negedge clock);
    chk("col_off", {7'h00, col_n}, 8'h01);
    // Fast link, then one cycle of traffic blinks it
    link = 1'b1;
    fast = 1'b1;
    repeat (2) @(negedge clock);
    chk("fast_link", {5'h00, fast_n, slow_n, link_n}, 8'h02);
    act = 1'b1;
    @(negedge clock);
    act = 1'b0;
    wait_fast(1'b1, HALF + 2);
    wait_fast(1'b0, 3 * HALF);
    // Slow link
    fast = 1'b0;
    repeat (2) @(negedge clock);
    chk("slow_link", {5'h00, fast_n, slow_n, link_n}, 8'h04);
    host_u.read_byte(15'h0002, 1'b0, rd, oe);
    chk("status_slow", rd, 8'h09);
    // Physical reset hides the link
    host_u.phy_assert();
    chk("link_in_phy_reset", {7'h00, link_n}, 8'h01);
    host_u.phy_release();
    chk("link_after_phy", {7'h00, link_n}, 8'h00);
    summarize();
  end
endmodule // nmhp_host_port_tb
